// ### lcd_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// watches command decode and sleep timing at the decoder ports
module lcd_chk
	import lcd_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic NRST_I,
	input wire logic CMD_DATA_SEL_I,
	input wire logic NWR_I,
	input wire logic [7:0] D_I,
	input wire logic READY_O,
	input wire logic CURSOR_SHOW_O,
	input wire logic CURSOR_FLASH_O,
	input wire logic TWIN_MARKER_O,
	input wire logic DISPLAY_ON_O,
	input wire logic OSC_RUN_O,
	input wire logic SLEEP_REQUEST_O,
	input wire logic REGULATOR_ON_O,
	input wire logic FOLLOWER_ON_O,
	input wire logic BOOST_ON_O,
	input wire logic [3:0] CONTRAST_O,
	input wire logic [6:0] ADDR_O,
	input wire logic SLEEP_O,
	input wire logic DRIVE_VDD_O
);
	logic nw_ff; // strobe one cycle back
	logic [6:0] a_ff; // address one cycle back
	wire tk = NWR_I & ~nw_ff & READY_O; // write taken
	wire tc = tk & ~CMD_DATA_SEL_I; // command taken
	wire [3:0] nb = D_I[7:4]; // command nibble
	wire [2:0] pw = {REGULATOR_ON_O, FOLLOWER_ON_O, BOOST_ON_O};
	wire slp = SLEEP_REQUEST_O & ~OSC_RUN_O & ~|pw; // sleep terms
	// history for strobe edge and address step
	always_ff @(posedge CLOCK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			nw_ff <= 1'b1;
			a_ff <= ADDR_RST;
		end else begin
			nw_ff <= NWR_I;
			a_ff <= ADDR_O;
		end
	end
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!NRST_I);
	disp_load_a: assert property (
		tc && nb == CMD_DISP |-> ##[1:2] {CURSOR_SHOW_O, CURSOR_FLASH_O,
		TWIN_MARKER_O, DISPLAY_ON_O} == D_I[3:0])
		else $error("display bits not loaded");
	psave_load_a: assert property (
		tc && nb == CMD_PSAVE |-> ##[1:2]
		{OSC_RUN_O, SLEEP_REQUEST_O} == D_I[1:0])
		else $error("power save bits not loaded");
	pctrl_load_a: assert property (
		tc && nb == CMD_PCTRL && !D_I[3] |-> ##[1:2] pw == D_I[2:0])
		else $error("supply enables not loaded");
	pctrl_keep_a: assert property (
		tc && nb == CMD_PCTRL && D_I[3] |=> $stable(pw) [*2])
		else $error("refused power control changed enables");
	contrast_load_a: assert property (
		tc && nb == CMD_CONTRAST |-> ##[1:2] CONTRAST_O == D_I[3:0])
		else $error("contrast not loaded");
	addr_set_a: assert property (
		tc && D_I[7] |-> ##[1:2] ADDR_O == D_I[6:0])
		else $error("address not loaded");
	data_step_a: assert property (
		tk && CMD_DATA_SEL_I |-> ##[1:2] ADDR_O == a_ff + 7'h01)
		else $error("address did not step");
	reset_clear_a: assert property (
		$rose(NRST_I) |-> {CURSOR_SHOW_O, CURSOR_FLASH_O, TWIN_MARKER_O,
		DISPLAY_ON_O, OSC_RUN_O, SLEEP_REQUEST_O, pw, ADDR_O} == 0)
		else $error("settings not cleared by reset");
	sleep_enter_a: assert property (
		slp |=> SLEEP_O && DRIVE_VDD_O)
		else $error("sleep state not entered");
endmodule // lcd_chk
bind lcd_cmd_decoder lcd_chk i_lcd_chk (.*);
`default_nettype wire

// ### lcd_cmd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R01: sleep when supplies, oscillator off, sleep set
// R02: sleep drives all display lines to VDD
// R03: sleep keeps rams and settings, halts circuits
// R04: reset clears cursor, flash, twin, display bits
// R05: reset clears oscillator, sleep, supplies, glyph select
// R06: host holds reset at least 10 us
// R07: resume within 1 us after reset release
// R08: cmd_data_sel low command, high data
// R09: host spaces instructions beyond cycle time
// R10: cursor home loads counter with 30 hex
// R11: display control loads four bits D3..D0
// R12: cursor hidden, reversed, or alternating by bits
// R13: alternation period about one second
// R14: cursor follows address counter
// R15: symbol window with show, no flash blinks
// R16: power save loads oscillator and sleep bits
// R17: power control D3 zero loads three enables
// R18: host runs oscillator before boost
// R19: system set loads line count, glyph select
// R20: host issues system set first
// R21: contrast command stores four bit level
// R22: D7 set loads address counter
// R23: data write stores then increments counter
// R24: counter range 00 through 7F hex
// R25: glyph select chooses ram for codes 0-3
// R26: system set decoded from nibble 0110
module lcd_cmd_decoder
	import lcd_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic NRST_I,
	input wire logic CMD_DATA_SEL_I,
	input wire logic NWR_I,
	input wire logic [7:0] D_I,
	input wire logic [6:0] SCAN_ADDR_I,
	input wire logic [7:0] SCAN_CODE_I,
	output logic [7:0] SCAN_DATA_O,
	output logic READY_O,
	output logic CURSOR_SHOW_O,
	output logic CURSOR_FLASH_O,
	output logic TWIN_MARKER_O,
	output logic DISPLAY_ON_O,
	output logic OSC_RUN_O,
	output logic SLEEP_REQUEST_O,
	output logic REGULATOR_ON_O,
	output logic FOLLOWER_ON_O,
	output logic BOOST_ON_O,
	output logic LINE_COUNT_HI_O,
	output logic LINE_COUNT_LO_O,
	output logic USER_GLYPH_SELECT_O,
	output logic [3:0] CONTRAST_O,
	output logic [6:0] ADDR_O,
	output logic SLEEP_O,
	output logic DRIVE_VDD_O,
	output logic CLOCKS_RUN_O,
	output logic CURSOR_ACTIVE_O,
	output logic CURSOR_REVERSE_O,
	output logic SYMBOL_BLINK_O,
	output logic GLYPH_FROM_RAM_O
);
	typedef enum logic [2:0] {
		LCD_ST_INIT = 3'b001, // waiting out the resume time
		LCD_ST_RUN = 3'b010, // normal operation
		LCD_ST_SLEEP = 3'b100 // sleep mode
	} lcd_state_e;

	lcd_state_e state_ff; // mode state
	lcd_state_e nxt_state; // next mode state
	logic [4:0] resume_ff; // cycles since reset release
	logic wr_d_ff; // delayed write strobe for edge detect
	logic [3:0] disp_ff; // show, flash, twin, display
	logic [1:0] psave_ff; // oscillator run, sleep request
	logic [2:0] pctrl_ff; // regulator, follower, boost
	logic [1:0] lines_ff; // line count hi, lo
	logic cg_ff; // glyph ram select
	logic [3:0] contrast_ff; // contrast level
	logic [6:0] addr_ff; // address counter
	logic flash_phase; // flash timer phase

	// write taken on the rising edge of the write strobe
	wire wr_act = ~NWR_I;
	wire wr_strobe = wr_d_ff & ~wr_act;
	wire ready = (state_ff != LCD_ST_INIT);
	wire take = wr_strobe & ready;
	wire is_cmd = take & ~CMD_DATA_SEL_I; // [R08]
	wire is_data = take & CMD_DATA_SEL_I; // [R08]
	wire [3:0] nib = D_I[7:4];
	wire cmd_home = is_cmd & (nib == CMD_HOME); // [R10]
	wire cmd_disp = is_cmd & (nib == CMD_DISP); // [R11]
	wire cmd_psave = is_cmd & (nib == CMD_PSAVE); // [R16]
	wire cmd_pctrl = is_cmd & (nib == CMD_PCTRL) & ~D_I[3]; // [R17]
	wire cmd_sys = is_cmd & (nib == CMD_SYSSET); // [R26]
	wire cmd_con = is_cmd & (nib == CMD_CONTRAST); // [R21]
	wire cmd_addr = is_cmd & D_I[7]; // [R22]

	// sleep once sleep is requested and all supplies and the oscillator are off
	wire supplies_off = (pctrl_ff == 3'h0) & ~psave_ff[1];
	wire want_sleep = psave_ff[0] & supplies_off; // [R01]
	wire asleep = (state_ff == LCD_ST_SLEEP);

	// next address: load, home or increment wrapping in 00..7F
	wire [6:0] addr_inc = addr_ff + 7'h01; // [R23] [R24]
	wire [6:0] nxt_addr = cmd_addr ? D_I[6:0] :
		cmd_home ? HOME_ADDR :
		is_data ? addr_inc : addr_ff; // [R10] [R22] [R23]

	// mode state transitions
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			LCD_ST_INIT: begin
				if (resume_ff == 5'(RESUME_CYC - 1)) begin
					nxt_state = LCD_ST_RUN; // [R07]
				end
			end
			LCD_ST_RUN: begin
				if (want_sleep) begin
					nxt_state = LCD_ST_SLEEP; // [R01]
				end
			end
			LCD_ST_SLEEP: begin
				if (!want_sleep) begin
					nxt_state = LCD_ST_RUN;
				end
			end
			default: begin
				nxt_state = LCD_ST_INIT;
			end
		endcase
	end

	// state, resume counter and strobe history
	always_ff @(posedge CLOCK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			state_ff <= LCD_ST_INIT;
			resume_ff <= '0;
			wr_d_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			resume_ff <= ready ? resume_ff : resume_ff + 5'h01;
			wr_d_ff <= wr_act;
		end
	end

	// display, power and glyph select settings, cleared by reset only
	always_ff @(posedge CLOCK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			disp_ff <= DISP_RST; // [R04]
			psave_ff <= PSAVE_RST; // [R05]
			pctrl_ff <= PCTRL_RST; // [R05]
			cg_ff <= CG_RST; // [R05]
		end else begin
			if (cmd_disp) disp_ff <= D_I[3:0]; // [R11]
			if (cmd_psave) psave_ff <= D_I[1:0]; // [R16]
			if (cmd_pctrl) pctrl_ff <= D_I[2:0]; // [R17]
			if (cmd_sys) cg_ff <= D_I[0]; // [R19]
		end
	end

	// line count, contrast and address counter
	always_ff @(posedge CLOCK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			lines_ff <= LINES_RST;
			contrast_ff <= CONTRAST_RST;
			addr_ff <= ADDR_RST;
		end else begin
			if (cmd_sys) lines_ff <= D_I[3:2]; // [R19]
			if (cmd_con) contrast_ff <= D_I[3:0]; // [R21]
			addr_ff <= nxt_addr; // [R14]
		end
	end

	// flash timer halts in sleep, as the cursor outputs do; command decode and ram writes keep running
	lcd_flash_timer #(
		.HALF(FLASH_CYC)
	) u_flash (
		.clk_i(CLOCK_I),
		.nrst_i(NRST_I),
		.run_i(~asleep & psave_ff[1]), // [R03] [R13]
		.phase_o(flash_phase)
	);

	// ram is never cleared by reset or sleep
	lcd_write_ram u_ram (
		.clk_i(CLOCK_I),
		.we_i(is_data), // [R03] [R23]
		.waddr_i(addr_ff),
		.wdata_i(D_I),
		.raddr_i(SCAN_ADDR_I),
		.rdata_o(SCAN_DATA_O)
	);

	// cursor presentation decode
	wire in_sym = (addr_ff >= SYM_BASE) & (addr_ff <= SYM_LAST);
	wire show = disp_ff[3];
	wire flash = disp_ff[2];
	wire cur_act = show & ~in_sym; // [R12] [R14]
	wire cur_rev = cur_act & (~flash | flash_phase); // [R12] [R13]
	wire sym_blink = in_sym & show & ~flash & flash_phase; // [R15]
	wire glyph_ram = cg_ff & (SCAN_CODE_I[7:2] == 6'h00); // [R25]

	assign READY_O = ready;
	assign CURSOR_SHOW_O = disp_ff[3];
	assign CURSOR_FLASH_O = disp_ff[2];
	assign TWIN_MARKER_O = disp_ff[1];
	assign DISPLAY_ON_O = disp_ff[0];
	assign OSC_RUN_O = psave_ff[1];
	assign SLEEP_REQUEST_O = psave_ff[0];
	assign REGULATOR_ON_O = pctrl_ff[2];
	assign FOLLOWER_ON_O = pctrl_ff[1];
	assign BOOST_ON_O = pctrl_ff[0];
	assign LINE_COUNT_HI_O = lines_ff[1];
	assign LINE_COUNT_LO_O = lines_ff[0];
	assign USER_GLYPH_SELECT_O = cg_ff;
	assign CONTRAST_O = contrast_ff;
	assign ADDR_O = addr_ff;
	assign SLEEP_O = asleep;
	assign DRIVE_VDD_O = asleep; // [R02]
	assign CLOCKS_RUN_O = ~asleep; // [R03]
	assign CURSOR_ACTIVE_O = cur_act & ~asleep;
	assign CURSOR_REVERSE_O = cur_rev & ~asleep;
	assign SYMBOL_BLINK_O = sym_blink & ~asleep;
	assign GLYPH_FROM_RAM_O = glyph_ram;
endmodule // lcd_cmd_decoder
`default_nettype wire

// ### lcd_flash_timer.sv
`timescale 1ns/1ps
`default_nettype none
// toggles a phase bit every half period while enabled
module lcd_flash_timer
	import lcd_pkg::*;
#(
	parameter int HALF = FLASH_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic run_i,
	output logic phase_o
);
	logic [FLASH_W-1:0] cnt_ff; // half period counter
	logic phase_ff; // current flash phase
	wire cnt_end = (cnt_ff == FLASH_W'(HALF - 1));
	wire [FLASH_W-1:0] nxt_cnt = cnt_end ? '0 : cnt_ff + 1'b1;
	// count only while running, halt otherwise
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_ff <= '0;
			phase_ff <= 1'b0;
		end else if (run_i) begin
			cnt_ff <= nxt_cnt;
			phase_ff <= phase_ff ^ cnt_end;
		end
	end
	assign phase_o = phase_ff;
endmodule // lcd_flash_timer
`default_nettype wire

// ### lcd_host.sv
`timescale 1ns/1ps
`default_nettype none
// host processor model driving the parallel write port
module lcd_host (
	input wire logic clk_i,
	output logic nwr_o,
	output logic sel_o,
	output logic [7:0] d_o
);
	// idle port at time zero
	initial begin
		nwr_o = 1'b1;
		sel_o = 1'b0;
		d_o = 8'h00;
	end
	// one write: strobe low a cycle, byte held past its rise
	task wr(input logic s, input logic [7:0] d);
		@(posedge clk_i);
		#2;
		sel_o = s;
		d_o = d;
		nwr_o = 1'b0;
		@(posedge clk_i);
		#2;
		nwr_o = 1'b1;
		repeat (3) @(posedge clk_i);
		#2;
		d_o = ~d; // released bus never shows the stale byte
	endtask
endmodule // lcd_host
`default_nettype wire

// ### lcd_pkg.sv
package lcd_pkg;
	// command nibbles in D7..D4
	localparam logic [3:0] CMD_HOME = 4'h1;
	localparam logic [3:0] CMD_DISP = 4'h3;
	localparam logic [3:0] CMD_PSAVE = 4'h4;
	localparam logic [3:0] CMD_PCTRL = 4'h5;
	localparam logic [3:0] CMD_SYSSET = 4'h6;
	localparam logic [3:0] CMD_CONTRAST = 4'h7;
	// address counter values
	localparam logic [6:0] HOME_ADDR = 7'h30;
	localparam logic [6:0] ADDR_RST = 7'h00;
	// symbol register window of the address space
	localparam logic [6:0] SYM_BASE = 7'h60;
	localparam logic [6:0] SYM_LAST = 7'h67;
	// reset values
	localparam logic [3:0] DISP_RST = 4'h0;
	localparam logic [1:0] PSAVE_RST = 2'h0;
	localparam logic [2:0] PCTRL_RST = 3'h0;
	localparam logic [1:0] LINES_RST = 2'h0;
	localparam logic CG_RST = 1'b0;
	localparam logic [3:0] CONTRAST_RST = 4'h0;
	// timing
	localparam int CLK_HZ = 20000000;
	localparam int RESUME_NS = 1000;
	localparam int RESUME_CYC = (RESUME_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int INIT_US = 10;
	localparam int INIT_CYC = INIT_US * (CLK_HZ / 1000000);
	localparam int FLASH_MS = 500;
	localparam int FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
	localparam int FLASH_W = 24;
	// ram sizes
	localparam int RAM_DEPTH = 128;
endpackage

// ### lcd_write_ram.sv
`timescale 1ns/1ps
`default_nettype none
// display ram: text, glyph and symbol storage, one write port
module lcd_write_ram
	import lcd_pkg::*;
(
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [6:0] waddr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [6:0] raddr_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [RAM_DEPTH]; // contents kept through reset and sleep
	logic [7:0] rd_ff; // registered read data
	// write and registered read
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rd_ff <= mem[raddr_i];
	end
	assign rdata_o = rd_ff;
endmodule // lcd_write_ram
`default_nettype wire

// ### tb_lcd_command_decoder_sleep_reset.sv
`timescale 1ns/1ps
`default_nettype none
// random and directed command traffic against an integer model
module tb_lcd_command_decoder_sleep_reset;
	import lcd_pkg::*;
	logic CLOCK_I, NRST_I, NWR_I, CMD_DATA_SEL_I, READY_O;
	logic [6:0] SCAN_ADDR_I, ADDR_O;
	logic [7:0] SCAN_CODE_I, D_I, SCAN_DATA_O, d;
	logic CURSOR_SHOW_O, CURSOR_FLASH_O, TWIN_MARKER_O, DISPLAY_ON_O;
	logic OSC_RUN_O, SLEEP_REQUEST_O, REGULATOR_ON_O, FOLLOWER_ON_O;
	logic BOOST_ON_O, LINE_COUNT_HI_O, LINE_COUNT_LO_O, SLEEP_O;
	logic USER_GLYPH_SELECT_O, DRIVE_VDD_O, CLOCKS_RUN_O, SYMBOL_BLINK_O;
	logic CURSOR_ACTIVE_O, CURSOR_REVERSE_O, GLYPH_FROM_RAM_O;
	logic [3:0] CONTRAST_O;
	int fails, total_checks, dp, ps, pc, ss, ct, ad, la, wok, sc, rc, k;
	int fc, ph, ia, cs; // flash cycles, phase, in symbol window, cursor on
	int mem [128]; // model of written ram bytes
	logic [8:0] seq [15] = '{9'h064, 9'h0FF, 9'h1AA, 9'h155, 9'h01F,
		9'h03F, 9'h0E0, 9'h038, 9'h050, 9'h041, 9'h040, 9'h06D, 9'h07F,
		9'h058, 9'h020}; // {data select, byte}
	logic [3:0] nt [8] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h0, 4'h2};
	wire [3:0] dsp = {CURSOR_SHOW_O, CURSOR_FLASH_O, TWIN_MARKER_O,
		DISPLAY_ON_O};
	wire [2:0] pwr = {REGULATOR_ON_O, FOLLOWER_ON_O, BOOST_ON_O};
	wire [2:0] sys = {LINE_COUNT_HI_O, LINE_COUNT_LO_O, USER_GLYPH_SELECT_O};
	wire [2:0] slw = {SLEEP_O, DRIVE_VDD_O, CLOCKS_RUN_O};
	wire [1:0] psv = {OSC_RUN_O, SLEEP_REQUEST_O};
	lcd_cmd_decoder i_lcd_cmd_decoder (.*);
	lcd_host i_lcd_host (.clk_i(CLOCK_I), .nwr_o(NWR_I),
		.sel_o(CMD_DATA_SEL_I), .d_o(D_I));
	// 20 MHz clock
	initial begin
		CLOCK_I = 1'b0;
		forever #25 CLOCK_I = ~CLOCK_I;
	end
	// edges since reset release
	always @(posedge CLOCK_I) rc <= NRST_I ? rc + 1 : 0;
	// edges on which the flash timer may run: oscillator on and awake
	always @(posedge CLOCK_I) fc <= NRST_I ? fc + (OSC_RUN_O && !SLEEP_O) : 0;
	task chk(input logic [7:0] g, input int e, input string m);
		total_checks++;
		if (g !== 8'(e)) begin
			fails++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task give_verdict();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// reset, early refused write, then wait for ready
	task rst();
		NRST_I = 1'b0;
		repeat (200) @(posedge CLOCK_I);
		#2;
		chk({dsp, psv}, 0, "reset a");
		chk({pwr, sys[0], READY_O}, 0, "reset b");
		NRST_I = 1'b1;
		{dp, ps, pc, ss, ct, ad} = '0;
		i_lcd_host.wr(1'b0, 8'h3F);
		while (READY_O !== 1'b1 && rc < 100) @(posedge CLOCK_I);
		#2;
		chk(8'(rc >= 19 && rc <= 22), 1, "ready");
		chk(dsp, 0, "early write");
	endtask
	// one write, model update, compare every result
	task cmd(input logic [8:0] c);
		SCAN_ADDR_I = 7'(la);
		sc = $urandom % 8;
		SCAN_CODE_I = 8'(sc);
		i_lcd_host.wr(c[8], c[7:0]);
		if (c[8]) mem[ad] = c[7:0];
		if (wok) chk(SCAN_DATA_O, mem[la], "ram");
		if (c[8]) begin
			la = ad;
			wok = 1;
			ad = (ad + 1) % 128;
		end else if (c[7]) ad = c[6:0];
		else case (c[7:4])
			1: ad = 48;
			3: dp = c[3:0];
			4: ps = c[1:0];
			5: if (!c[3]) pc = c[2:0];
			6: ss = {c[3:2], c[0]};
			7: ct = c[3:0];
			default: ;
		endcase
		chk(dsp, dp, "display");
		chk(psv, ps, "power save");
		chk(pwr, pc, "power control");
		chk(sys, ss, "system set");
		chk(CONTRAST_O, ct, "contrast");
		chk(ADDR_O, ad, "address");
		chk(slw, (ps == 1 && pc == 0) ? 6 : 1, "sleep");
		chk(GLYPH_FROM_RAM_O, ss % 2 && sc < 4, "glyph");
		ia = ad > 95 && ad < 104;
		ph = (fc / FLASH_CYC) % 2;
		cs = (dp / 8) && !(ps == 1 && pc == 0);
		chk(CURSOR_ACTIVE_O, cs && !ia, "cursor");
		chk(CURSOR_REVERSE_O, cs && !ia && (dp / 4 % 2 == 0 || ph),
			"reverse");
		chk(SYMBOL_BLINK_O, cs && ia && dp / 4 % 2 == 0 && ph,
			"blink");
	endtask
	initial begin
		NRST_I = 1'b0;
		SCAN_ADDR_I = 7'h00;
		SCAN_CODE_I = 8'h00;
		void'($urandom(81));
		rst();
		foreach (seq[i]) cmd(seq[i]);
		repeat (60) begin
			k = $urandom % 10;
			d = 8'($urandom);
			if (k == 0) d[7] = 1'b1;
			else if (k > 1) d[7:4] = nt[k - 2];
			if (k > 1 && d[7:4] == CMD_PCTRL && ps < 2) d[0] = 1'b0;
			cmd({k == 1, d});
		end
		rst();
		cmd(9'h064);
		give_verdict();
	end
	// run is about 820 cycles; allow 15000, about eighteen times that
	initial begin
		#(50 * 15000);
		fails++;
		give_verdict();
	end
endmodule // tb_lcd_command_decoder_sleep_reset
`default_nettype wire
